// ==== design/ica_pkg.sv ====
// Constants and types shared by the I2C configuration access slave.
// Assumes a single system clock and an I2C link clocked by the bus master.
package ica_pkg;

    // =========================================================
    // Command opcodes and bus addressing
    localparam logic [2:0] OPC_WRITE = 3'h3;
    localparam logic [2:0] OPC_READ = 3'h4;
    localparam logic [6:0] BUS_ADDR_BASE = 7'h68;
    localparam logic [4:0] PORT_LAST = 5'h05;

    // =========================================================
    // Field positions inside the address and command bytes
    localparam int RW_BIT = 0;
    localparam int OPC_MSB = 2;
    localparam int PSEL_HI_MSB = 3;
    localparam int PSEL_LO_BIT = 7;
    localparam int BE_MSB = 5;
    localparam int BE_LSB = 2;
    localparam int ADDR_HI_MSB = 1;

    // =========================================================
    // Byte and cycle counts
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] IDX_CMD0 = 4'h0;
    localparam logic [3:0] IDX_CMD1 = 4'h1;
    localparam logic [3:0] IDX_CMD2 = 4'h2;
    localparam logic [3:0] IDX_CMD3 = 4'h3;
    localparam logic [3:0] IDX_DATA_LAST = 4'h7;
    localparam logic [1:0] LANE_FIRST = 2'h3;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // =========================================================
    // Reset values
    localparam logic [31:0] BUF_RST = 32'h0000_0000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // =========================================================
    // Protocol engine states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_RX = 7'h04,
        ST_ACK = 7'h08,
        ST_TX = 7'h10,
        ST_TACK = 7'h20,
        ST_SKIP = 7'h40
    } ica_state_t;

endpackage

// ==== design/ica_link_rx.sv ====
// Receive shifter that runs on the I2C serial clock itself.
// Assumes SDA is stable around each rising SCL edge, as the bus requires;
// the clock may stop between frames, so nothing here waits for an edge.
`timescale 1ns/10ps
module ica_link_rx (
    // Link clock and reset
    input wire logic scl_i,
    input wire logic nrst_i,
    // Serial data
    input wire logic sda_i,
    // Last eight bits seen, newest in bit 0
    output logic [7:0] byte_o
);

    typedef struct packed {
        logic [7:0] sh;
    } ica_link_st_t;

    ica_link_st_t q;
    ica_link_st_t d;

    // =========================================================
    // Shift in one bit per rising SCL edge
    always_comb begin
        d = q;
        d.sh = {q.sh[6:0], sda_i};
    end

    always_ff @(posedge scl_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '{sh: ica_pkg::BYTE_RST};
        end else begin
            q <= d;
        end
    end

    // Held only until the ninth rising SCL edge shifts in the next bit
    assign byte_o = q.sh;

endmodule

// ==== design/ica_top.sv ====
// I2C slave that gives a bus master read and write access to the
// 32-bit per-port configuration registers through a simple request port.
// Assumes the register fabric answers a read one clk_i cycle after
// cfg_rd_o and takes a write in the cycle cfg_wr_o is high.
//
// Notes on behaviour
// R1: Opcode 011b in command byte 0 makes the next four data bytes a write.
// R2: Opcode 100b in command byte 0 fetches the addressed register.
// R3: Master reads with a command transaction, then a read transaction.
// R4: Read data is returned only when address byte bit 0 is one.
// R5: Accepted read command copies the register into a holding buffer.
// R6: Read data goes out byte 3 first, byte 0 last.
// R7: Extra read bytes wrap round, starting again from byte 3.
// R8: Repeated start instead of stop is accepted between the two phases.
// R9: Port select is command byte 1 bits 3:0 above command byte 2 bit 7.
// R10: Port select 0 to 5 addresses the matching switch port.
// R11: Command byte 2 bits 5:2 enable register bytes 0 to 3 for writing.
// R12: Address 11:10 from byte 2 bits 1:0, 9:2 from byte 3, 1:0 zero.
// R13: Write data arrives most significant byte first, then a stop.
// R14: Default bus address is 68h, write addressing byte D0h.
// R15: The three strap inputs are merged into the low bus address bits.
// R16: Reserved command bits are ignored whatever their value.
// R17: Accepted bytes are acknowledged; a write commits after all four bytes.
`timescale 1ns/10ps
module ica_top (
    // System clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // I2C link, SDA is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Bus address straps
    input wire logic [2:0] addr_strap_i,
    // Register fabric request
    output logic cfg_wr_o,
    output logic cfg_rd_o,
    output logic [4:0] cfg_port_o,
    output logic [11:0] cfg_addr_o,
    output logic [3:0] cfg_be_o,
    output logic [31:0] cfg_wdata_o,
    input wire logic [31:0] cfg_rdata_i,
    // Status
    output logic busy_o
);

    // =========================================================
    // State record
    typedef struct packed {
        ica_pkg::ica_state_t st;
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic [2:0] strap_m;
        logic [2:0] strap_s;
        logic [1:0] strap_cnt;
        logic [6:0] dev_addr;
        logic [3:0] bit_cnt;
        logic [3:0] byte_idx;
        logic rd_dir;
        logic sda_oe;
        logic [7:0] byte_q;
        logic [7:0] tx_sh;
        logic [1:0] tx_idx;
        logic [2:0] opc;
        logic [4:0] port;
        logic [3:0] be;
        logic [9:0] addr;
        logic [31:0] wdata;
        logic [31:0] hold;
        logic rd_pend;
        logic wr_p;
        logic rd_p;
    } ica_top_st_t;

    // Bus lines idle high, so the edge detectors start from high
    localparam ica_top_st_t Q_RST = '{
        st: ica_pkg::ST_IDLE,
        scl_m: 1'b1,
        scl_s: 1'b1,
        scl_p: 1'b1,
        sda_m: 1'b1,
        sda_s: 1'b1,
        sda_p: 1'b1,
        dev_addr: ica_pkg::BUS_ADDR_BASE,
        hold: ica_pkg::BUF_RST,
        default: '0
    };

    ica_top_st_t q;
    ica_top_st_t d;
    logic [7:0] rx_byte;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic port_ok;

    // =========================================================
    // Pick one byte lane of the holding buffer
    function automatic logic [7:0] lane_of(input logic [31:0] w,
                                           input logic [1:0] idx);
        logic [7:0] b;
        b = w[7:0];
        case (idx)
            2'h3: b = w[31:24];
            2'h2: b = w[23:16];
            2'h1: b = w[15:8];
            default: b = w[7:0];
        endcase
        return b;
    endfunction

    // Level of sda_oe for a lane's first bit: pull low for a zero
    function automatic logic lane_drive(input logic [31:0] w,
                                        input logic [1:0] idx);
        logic [7:0] b;
        b = lane_of(w, idx);
        return ~b[7];
    endfunction

    // All eight bits of a byte have been clocked in or out
    function automatic logic byte_done(input logic [3:0] cnt);
        return (cnt == ica_pkg::BYTE_BITS);
    endfunction

    // =========================================================
    // Link-side shifter on the serial clock
    ica_link_rx u_link_rx (
        .scl_i(scl_i),
        .nrst_i(nrst_i),
        .sda_i(sda_i),
        .byte_o(rx_byte)
    );

    // =========================================================
    // Edges and frame conditions, seen only after the synchronisers
    assign scl_rise = q.scl_s & ~q.scl_p;
    assign scl_fall = ~q.scl_s & q.scl_p;
    assign bus_start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    assign bus_stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    assign port_ok = (q.port <= ica_pkg::PORT_LAST); // R10

    // =========================================================
    // Next state
    always_comb begin
        d = q;
        d.wr_p = 1'b0;
        d.rd_p = 1'b0;

        // Two flops per pin before any logic looks at it
        d.scl_m = scl_i;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = sda_i;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.strap_m = addr_strap_i;
        d.strap_s = q.strap_m;

        // Straps are caught once, just after reset release
        // Later strap moves are ignored so the address cannot shift mid-frame
        if (q.strap_cnt != ica_pkg::STRAP_SETTLE) begin
            d.strap_cnt = q.strap_cnt + 2'h1;
            d.dev_addr = ica_pkg::BUS_ADDR_BASE | {4'h0, q.strap_s}; // R15
        end

        // Fabric answers one cycle after the read strobe, so the strobe
        // cycle is let pass before the buffer takes the data
        if (q.rd_p) begin
            d.rd_pend = 1'b1;
        end
        if (q.rd_pend) begin
            d.rd_pend = 1'b0;
            d.hold = cfg_rdata_i; // R5
        end

        case (q.st)
            ica_pkg::ST_IDLE: begin
                // Nothing to do until a start is seen
                d.sda_oe = 1'b0;
            end
            ica_pkg::ST_ADDR, ica_pkg::ST_RX: begin
                if (scl_rise) begin
                    d.bit_cnt = q.bit_cnt + 4'h1;
                    // Shifter is stable until the ninth rising edge, which
                    // is what makes this read across clock domains safe
                    if (q.bit_cnt == ica_pkg::BYTE_BITS - 4'h1) begin
                        d.byte_q = rx_byte;
                    end
                end else if (scl_fall && byte_done(q.bit_cnt)) begin
                    d.bit_cnt = 4'h0;
                    if (q.st == ica_pkg::ST_ADDR) begin
                        if (q.byte_q[7:1] == q.dev_addr) begin // R14
                            d.sda_oe = 1'b1; // R17
                            d.st = ica_pkg::ST_ACK;
                            d.rd_dir = q.byte_q[ica_pkg::RW_BIT]; // R4
                            d.byte_idx = ica_pkg::IDX_CMD0;
                        end else begin
                            d.st = ica_pkg::ST_SKIP;
                        end
                    end else if (q.byte_idx > ica_pkg::IDX_DATA_LAST) begin
                        // Nothing more is expected: leave it unacknowledged
                        d.st = ica_pkg::ST_SKIP;
                    end else begin
                        d.sda_oe = 1'b1; // R17
                        d.st = ica_pkg::ST_ACK;
                        d.byte_idx = q.byte_idx + 4'h1;
                        case (q.byte_idx)
                            ica_pkg::IDX_CMD0: begin
                                // Upper bits are don't-care
                                d.opc = q.byte_q[ica_pkg::OPC_MSB:0]; // R16
                            end
                            ica_pkg::IDX_CMD1: begin
                                d.port[4:1] =
                                    q.byte_q[ica_pkg::PSEL_HI_MSB:0]; // R9
                            end
                            ica_pkg::IDX_CMD2: begin
                                d.port[0] = q.byte_q[ica_pkg::PSEL_LO_BIT]; // R9
                                d.be =
                                    q.byte_q[ica_pkg::BE_MSB:ica_pkg::BE_LSB]; // R11
                                d.addr[9:8] =
                                    q.byte_q[ica_pkg::ADDR_HI_MSB:0]; // R12
                            end
                            ica_pkg::IDX_CMD3: begin
                                d.addr[7:0] = q.byte_q; // R12
                                if (q.opc == ica_pkg::OPC_READ) begin // R2
                                    if (port_ok) begin
                                        d.rd_p = 1'b1; // R5
                                    end else begin
                                        // No such port: return zeros
                                        d.hold = ica_pkg::BUF_RST; // R10
                                    end
                                end
                            end
                            default: begin
                                // Data bytes, most significant first
                                d.wdata = {q.wdata[23:0], q.byte_q}; // R13
                                if (q.byte_idx == ica_pkg::IDX_DATA_LAST &&
                                    q.opc == ica_pkg::OPC_WRITE &&
                                    port_ok) begin // R1
                                    d.wr_p = 1'b1; // R17
                                end
                            end
                        endcase
                    end
                end
            end
            ica_pkg::ST_ACK: begin
                // Acknowledge is held through one full SCL high time
                if (scl_fall) begin
                    if (q.rd_dir) begin
                        d.tx_sh = lane_of(q.hold, ica_pkg::LANE_FIRST); // R6
                        d.tx_idx = ica_pkg::LANE_FIRST - 2'h1;
                        d.sda_oe = lane_drive(q.hold, ica_pkg::LANE_FIRST);
                        d.st = ica_pkg::ST_TX;
                    end else begin
                        d.sda_oe = 1'b0;
                        d.st = ica_pkg::ST_RX;
                    end
                    d.bit_cnt = 4'h0;
                end
            end
            ica_pkg::ST_TX: begin
                if (scl_rise) begin
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end else if (scl_fall) begin
                    if (byte_done(q.bit_cnt)) begin
                        // Let go so the master can acknowledge
                        d.sda_oe = 1'b0;
                        d.bit_cnt = 4'h0;
                        d.st = ica_pkg::ST_TACK;
                    end else begin
                        d.tx_sh = {q.tx_sh[6:0], 1'b0};
                        d.sda_oe = ~q.tx_sh[6];
                    end
                end
            end
            ica_pkg::ST_TACK: begin
                if (scl_rise) begin
                    // A not-acknowledge ends the return of data
                    if (q.sda_s) begin
                        d.st = ica_pkg::ST_SKIP;
                    end
                end else if (scl_fall) begin
                    // Two-bit index wraps from byte 0 back to byte 3
                    d.tx_sh = lane_of(q.hold, q.tx_idx); // R7
                    d.sda_oe = lane_drive(q.hold, q.tx_idx);
                    d.tx_idx = q.tx_idx - 2'h1; // R6
                    d.st = ica_pkg::ST_TX;
                end
            end
            ica_pkg::ST_SKIP: begin
                d.sda_oe = 1'b0;
            end
            default: begin
                d.sda_oe = 1'b0;
                d.st = ica_pkg::ST_IDLE;
            end
        endcase

        // Frame conditions override whatever the byte engine was doing
        // A cut byte never reaches the fabric: strobes fire at byte end
        if (bus_stop) begin
            d.sda_oe = 1'b0;
            d.st = ica_pkg::ST_IDLE;
        end
        if (bus_start) begin
            // Holding buffer survives a repeated start
            d.sda_oe = 1'b0; // R8
            d.bit_cnt = 4'h0;
            d.st = ica_pkg::ST_ADDR; // R3
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= Q_RST;
        end else begin
            q <= d;
        end
    end

    // =========================================================
    // Outputs
    assign sda_o = 1'b0; // Open drain: only ever pulls low
    assign sda_oe_o = q.sda_oe;
    assign cfg_wr_o = q.wr_p;
    assign cfg_rd_o = q.rd_p;
    assign cfg_port_o = q.port;
    assign cfg_addr_o = {q.addr, 2'h0}; // R12
    assign cfg_be_o = q.be; // R11
    assign cfg_wdata_o = q.wdata;
    assign busy_o = (q.st != ica_pkg::ST_IDLE);

endmodule

// ==== tb/ica_top_sva.sv ====
// Concurrent checks on the ports of the configuration access slave.
// Assumes it is bound into ica_top and watches the clk_i domain only.
`timescale 1ns/10ps
module ica_top_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Link pins
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // Fabric request and status
    input wire logic cfg_wr_o,
    input wire logic cfg_rd_o,
    input wire logic [4:0] cfg_port_o,
    input wire logic [11:0] cfg_addr_o,
    input wire logic busy_o
);
    // ==========================================================
    // Common clocking
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // ==========================================================
    // Strobes: one cycle high, then low again
    sequence wr_pulse_s;
        cfg_wr_o ##1 !cfg_wr_o;
    endsequence
    sequence rd_pulse_s;
        cfg_rd_o ##1 !cfg_rd_o;
    endsequence

    wr_pulse_a: assert property (cfg_wr_o |-> wr_pulse_s)
        else $error("write strobe wider than one cycle");
    rd_pulse_a: assert property (cfg_rd_o |-> rd_pulse_s)
        else $error("read strobe wider than one cycle");
    strobe_excl_a: assert property (!(cfg_wr_o && cfg_rd_o))
        else $error("read and write strobes together");
    addr_align_a: assert property (cfg_addr_o[1:0] == 2'h0)
        else $error("register address not dword aligned");
    wr_port_a: assert property (cfg_wr_o |-> cfg_port_o <= 5'h05)
        else $error("write issued to a port above five");
    wr_busy_a: assert property (cfg_wr_o |-> busy_o)
        else $error("write issued outside a frame");

    // ==========================================================
    // Link pin behaviour; data may only move while SCL is low
    oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("SDA drive changed while SCL high");
    idle_quiet_a: assert property (!busy_o |-> !sda_oe_o)
        else $error("SDA driven while engine idle");
    open_drain_a: assert property (sda_o == 1'b0)
        else $error("SDA output level not low");
    oe_stand_a: assert property ($rose(sda_oe_o) |-> sda_oe_o[*8])
        else $error("SDA drive shorter than eight cycles");
    port_hold_a: assert property ($changed(cfg_port_o) |-> busy_o)
        else $error("port select moved outside a frame");
endmodule

bind ica_top ica_top_sva u_ica_top_sva (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .cfg_wr_o(cfg_wr_o), .cfg_rd_o(cfg_rd_o),
    .cfg_port_o(cfg_port_o), .cfg_addr_o(cfg_addr_o), .busy_o(busy_o)
);

// ==== tb/ica_mst_model.sv ====
// Behavioural I2C bus master that drives SCL and pulls SDA low.
// Assumes the bench resolves SDA with a pull-up; SCL idles high.
`timescale 1ns/10ps
module ica_mst_model #(
    parameter int QTR = 500
) (
    // Link lines
    output logic scl_o,
    output logic pull_o,
    input wire logic sda_i
);
    // Idle bus: clock stands high, data released to the pull-up
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end

    // Start or repeated start: SDA falls while SCL is high
    task automatic start();
        pull_o = 1'b0;
        #QTR scl_o = 1'b1;
        #QTR pull_o = 1'b1;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask

    // Stop: SDA rises while SCL is high, ends every frame
    task automatic stop();
        pull_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR pull_o = 1'b0;
        #QTR;
    endtask

    // Nine bits, data set while SCL low, sampled mid high
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            pull_o = !d[i];
            #QTR scl_o = 1'b1;
            #QTR q[i] = sda_i;
            #QTR scl_o = 1'b0;
            #QTR;
        end
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the I2C configuration access slave.
// Assumes a slow SCL from the master model and a one-cycle fabric.
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic scl, pull, sda, sda_o, sda_oe_o, cfg_wr_o, cfg_rd_o, busy_o;
    logic [4:0] cfg_port_o, w_port;
    logic [11:0] cfg_addr_o, w_addr;
    logic [3:0] cfg_be_o, w_be;
    logic [31:0] cfg_wdata_o, w_data, cfg_rdata_i = 32'h0000_0000;
    logic [2:0] strap = 3'h0;
    logic rd_seen = 1'b0;
    int num_errors = 0;
    int cmp_count = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;

    // ==========================================================
    // Clock, wire resolution and instances
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // Open drain with pull-up: low if either party pulls
    assign sda = ~(pull | (sda_oe_o & ~sda_o));

    ica_mst_model u_ica_mst_model (.scl_o(scl), .pull_o(pull), .sda_i(sda));
    ica_top u_ica_top (
        .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_i(strap),
        .cfg_wr_o(cfg_wr_o), .cfg_rd_o(cfg_rd_o), .cfg_port_o(cfg_port_o),
        .cfg_addr_o(cfg_addr_o), .cfg_be_o(cfg_be_o),
        .cfg_wdata_o(cfg_wdata_o), .cfg_rdata_i(cfg_rdata_i), .busy_o(busy_o)
    );

    // Fabric: read data is a pattern of port and address, so a wrong
    // selector shows up in the returned bytes; it stands only in the
    // cycle after the strobe, all ones otherwise, to catch early capture
    always @(negedge clk_i) begin
        rd_seen <= cfg_rd_o;
        cfg_rdata_i <= (rd_seen === 1'b1) ?
            {3'h0, cfg_port_o, 4'h0, cfg_addr_o, 8'hA5} : 32'hFFFF_FFFF;
    end
    // Fabric: log each strobe taken, away from the launching edge
    always @(negedge clk_i) begin
        if (cfg_rd_o === 1'b1) rd_cnt++;
        if (cfg_wr_o === 1'b1) begin
            wr_cnt++;
            {w_port, w_addr, w_be, w_data} =
                {cfg_port_o, cfg_addr_o, cfg_be_o, cfg_wdata_o};
        end
    end

    // ==========================================================
    // Shared helpers
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic wbyte(input logic [7:0] d, input logic ack);
        logic [8:0] q;
        u_ica_mst_model.xfer({d, 1'b1}, q);
        chk(q[0] === !ack, "acknowledge level wrong");
    endtask

    // Start, write address D0h and four command bytes
    task automatic cmd(input logic [2:0] opc, input logic [4:0] port,
                       input logic [3:0] be, input logic [11:0] addr);
        u_ica_mst_model.start();
        wbyte(8'hD0, 1'b1);
        wbyte({5'h00, opc}, 1'b1);
        wbyte({4'h0, port[4:1]}, 1'b1);
        wbyte({port[0], 1'b0, be, addr[11:10]}, 1'b1);
        wbyte(addr[9:2], 1'b1);
    endtask

    task automatic final_report();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic sc_write();
        int n0;
        n0 = wr_cnt;
        cmd(3'h3, 5'h03, 4'hA, 12'hF8C);
        for (int i = 0; i < 4; i++) wbyte(8'h12 + 8'(i * 34), 1'b1);
        u_ica_mst_model.stop();
        chk(wr_cnt == n0 + 1, "write count");
        chk(w_port === 5'h03 && w_addr === 12'hF8C, "write target");
        chk(w_be === 4'hA, "write byte enables");
        chk(w_data === 32'h1234_5678, "write data order");
    endtask

    // Short write, and a full write to an absent port: neither commits
    task automatic sc_short();
        int n0;
        n0 = wr_cnt;
        cmd(3'h3, 5'h00, 4'hF, 12'h3F8);
        for (int i = 0; i < 3; i++) wbyte(8'h55, 1'b1);
        u_ica_mst_model.stop();
        chk(wr_cnt == n0, "partial write committed");
        cmd(3'h3, 5'h06, 4'hF, 12'h3F8);
        for (int i = 0; i < 4; i++) wbyte(8'h55, 1'b1);
        u_ica_mst_model.stop();
        chk(wr_cnt == n0, "write to absent port committed");
    endtask

    // Read in two frames or merged by a repeated start, six bytes to see
    // the wrap; a port above five fetches nothing and returns zeros
    task automatic sc_read(input logic merged, input logic [4:0] port);
        logic [8:0] q;
        logic [31:0] exp;
        int n0;
        n0 = rd_cnt;
        exp = (port <= 5'h05) ?
            {3'h0, port, 4'h0, 12'h3F8, 8'hA5} : 32'h0000_0000;
        cmd(3'h4, port, 4'hF, 12'h3F8);
        if (!merged) u_ica_mst_model.stop();
        u_ica_mst_model.start();
        wbyte(8'hD1, 1'b1);
        for (int i = 0; i < 6; i++) begin
            u_ica_mst_model.xfer({8'hFF, i == 5}, q);
            chk(q[8:1] === exp[8 * (3 - i % 4) +: 8], "read byte");
        end
        u_ica_mst_model.stop();
        chk(rd_cnt == n0 + ((port <= 5'h05) ? 1 : 0), "read fetches");
    endtask

    // Foreign bus address is not acknowledged
    task automatic sc_foreign();
        u_ica_mst_model.start();
        wbyte(8'hD2, 1'b0);
        u_ica_mst_model.stop();
    endtask

    // Second reset with straps at 2: address 6Ah answers, 68h no longer
    task automatic sc_strap();
        @(negedge clk_i);
        nrst_i = 1'b0;
        strap = 3'h2;
        repeat (6) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        u_ica_mst_model.start();
        wbyte(8'hD4, 1'b1);
        u_ica_mst_model.stop();
        u_ica_mst_model.start();
        wbyte(8'hD0, 1'b0);
        u_ica_mst_model.stop();
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (6) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        sc_write();
        sc_short();
        sc_read(1'b0, 5'h05);
        sc_read(1'b1, 5'h02);
        sc_read(1'b1, 5'h07);
        sc_foreign();
        sc_strap();
        repeat (20) @(negedge clk_i);
        final_report();
    end
    initial begin
        #5000000;
        num_errors++;
        final_report();
    end
endmodule
